// *** pdcsw_pkg.sv ***
// constants shared by the power die control, status and watchdog block
package pdcsw_pkg;

    // register addresses on the internal serial link
    localparam logic [4:0] ADDR_SYS_CTRL = 5'h00;
    localparam logic [4:0] ADDR_HS_OUT = 5'h02;
    localparam logic [4:0] ADDR_HS_STAT = 5'h04;
    localparam logic [4:0] ADDR_WDOG_CTRL = 5'h0B;
    localparam logic [4:0] ADDR_SYS_STAT = 5'h0C;

    // system_control fields
    localparam int CTRL_PSE = 7;
    localparam int CTRL_STOP = 6;
    localparam int CTRL_SLEEP = 5;
    localparam int CTRL_TSD_LOWER = 4;
    localparam int CTRL_TSD_UPPER = 3;
    localparam int CTRL_VSD = 2;
    localparam logic [7:0] STOP_QUAL_MASK = 8'hBC;
    localparam logic [7:0] SLEEP_QUAL_MASK = 8'hDC;

    // high side output and status fields
    localparam int HSOUT_5V_ON = 7;
    localparam int HIGH_SIDE_STATUS_5V_OCF = 7;

    // watchdog_control fields
    localparam int WDOG_ENABLE = 7;
    localparam int WDOG_KICK = 6;

    // frame layout: A4..A0, read/write, parity, unused, then eight data bits
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_SAMPLES = 5'h06;
    localparam int FRAME_RW = 10;

    // reset value of the input synchroniser, slave select idles high
    localparam logic [17:0] SYNC_RESET = 18'h20000;

    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int WDOG_MIN_PERIOD_MS = 10;
    localparam int WDOG_BASE_CYCLES = CLK_HZ / 1000 * WDOG_MIN_PERIOD_MS;
    localparam int LIN_CL_TIME_US = 200;
    localparam int LIN_CL_CYCLES = CLK_HZ / 1_000_000 * LIN_CL_TIME_US;

endpackage

// *** pdcsw_core.sv ***
// control, status and window watchdog logic of the power die, reached over the internal serial link
// Summary of operation
// - pwm bit makes high side follow pwm
// - high side overcurrent flag, write one clears
// - 5v output overcurrent flag bit 7
// - power stage enable gates all power outputs
// - stop bit requests stop, irq clears
// - stop only if bits 7..2 zero
// - sleep bit requests sleep, irq clears
// - sleep only if bits 7..2 zero
// - hot die shuts upper drivers unless disabled
// - hot die shuts lower drivers unless disabled
// - voltage fault shuts power stages unless disabled
// - two bit lin slew select
// - lin current limit status, timed transmitter off
// - voltage failure is low or high flag
// - status mirrors temperature, aux, 5v flags
// - group fail bits for high sides, bridges
// - watchdog enable set only, reset clears
// - kick restarts counter at frame end
// - expiry or early kick gives system reset
// - period select 80, 40, 20, 10 ms
// - stop halts watchdog, wake clears timer
// - sleep halts watchdog and clears enable
// - writes land only at slave select rise
// - pwm rising edge re-enables tripped high side
`timescale 1ns/1ps
module pdcsw_core #(
    parameter int unsigned WDOG_BASE_CYCLES = pdcsw_pkg::WDOG_BASE_CYCLES,
    parameter int unsigned LIN_CL_CYCLES = pdcsw_pkg::LIN_CL_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic spi_ss_b_i,
    input wire logic spi_sck_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire logic pwm_i,
    input wire logic [2:0] hs_oc_i,
    input wire logic switched_5v_oc_i,
    input wire logic aux_high_side_overcurrent_flag_i,
    input wire logic [3:0] hb_oc_i,
    input wire logic lin_cl_i,
    input wire logic overtemperature_flag_i,
    input wire logic low_voltage_flag_i,
    input wire logic high_voltage_flag_i,
    input wire logic cpu_irq_i,
    output logic [2:0] hs_drive_o,
    output logic [3:0] hb_upper_en_o,
    output logic [3:0] hb_lower_en_o,
    output logic switched_5v_output_o,
    output logic lin_tx_en_o,
    output logic ain_source_en_o,
    output logic [1:0] lin_slew_select_o,
    output logic stop_req_o,
    output logic sleep_req_o,
    output logic wdog_reset_o
);

    function automatic logic [22:0] wdog_period_cycles(input logic [1:0] sel);
        wdog_period_cycles = 23'(WDOG_BASE_CYCLES) << (2'd3 - sel);
    endfunction

    // every input crosses from outside the clock domain
    logic [17:0] sync_a;
    logic [17:0] sync_b;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sync_a <= pdcsw_pkg::SYNC_RESET;
            sync_b <= pdcsw_pkg::SYNC_RESET;
        end else begin
            sync_a <= {spi_ss_b_i, spi_sck_i, spi_mosi_i, pwm_i, hs_oc_i, switched_5v_oc_i,
                       aux_high_side_overcurrent_flag_i, hb_oc_i, lin_cl_i, overtemperature_flag_i,
                       low_voltage_flag_i, high_voltage_flag_i, cpu_irq_i};
            sync_b <= sync_a;
        end
    end

    logic ss_b, sck, mosi, pwm, sv_oc, aux_oc, lin_cl, ot_flag, lv_flag, hv_flag, cpu_irq;
    logic [2:0] hs_oc;
    logic [3:0] hb_oc;
    assign ss_b = sync_b[17];
    assign sck = sync_b[16];
    assign mosi = sync_b[15];
    assign pwm = sync_b[14];
    assign hs_oc = sync_b[13:11];
    assign sv_oc = sync_b[10];
    assign aux_oc = sync_b[9];
    assign hb_oc = sync_b[8:5];
    assign lin_cl = sync_b[4];
    assign ot_flag = sync_b[3];
    assign lv_flag = sync_b[2];
    assign hv_flag = sync_b[1];
    assign cpu_irq = sync_b[0];

    logic ss_d, sck_d, pwm_d, stop_d;
    logic stop_req, sleep_req;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ss_d <= 1'b1;
            sck_d <= 1'b0;
            pwm_d <= 1'b0;
            stop_d <= 1'b0;
        end else begin
            ss_d <= ss_b;
            sck_d <= sck;
            pwm_d <= pwm;
            stop_d <= stop_req;
        end
    end

    logic frame_start, frame_end, sck_rise, sck_fall, pwm_rise;
    assign frame_start = ss_d & ~ss_b;
    assign frame_end = ~ss_d & ss_b;
    assign sck_rise = ~ss_b & sck & ~sck_d;
    assign sck_fall = ~ss_b & ~sck & sck_d;
    assign pwm_rise = pwm & ~pwm_d;

    // serial frame: sample on falling clock, shift out on rising clock
    logic [4:0] fall_cnt, rise_cnt;
    logic [15:0] rx_sr;
    logic [7:0] status_snap, data_snap, rd_data, sys_status;
    logic miso;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            fall_cnt <= 5'h00;
            rise_cnt <= 5'h00;
            rx_sr <= 16'h0000;
            status_snap <= 8'h00;
            data_snap <= 8'h00;
            miso <= 1'b0;
        end else if (frame_start) begin
            fall_cnt <= 5'h00;
            rise_cnt <= 5'h00;
            status_snap <= sys_status;
            miso <= sys_status[7];
        end else begin
            if (sck_fall) begin
                rx_sr <= {rx_sr[14:0], mosi};
                if (fall_cnt != 5'h1F) begin
                    fall_cnt <= fall_cnt + 5'h01;
                end
                // register contents are caught while the parity bit goes by
                if (fall_cnt == pdcsw_pkg::ADDR_SAMPLES) begin
                    data_snap <= rd_data;
                end
            end
            if (sck_rise && rise_cnt < pdcsw_pkg::FRAME_BITS) begin
                miso <= (rise_cnt[3] ? data_snap[3'd7 - rise_cnt[2:0]] : status_snap[3'd7 - rise_cnt[2:0]]);
                rise_cnt <= rise_cnt + 5'h01;
            end
        end
    end
    assign spi_miso_o = miso;
    assign spi_miso_oe_o = ~ss_b;

    // a frame with the wrong bit count or bad parity writes nothing
    logic wr_commit;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    assign wr_addr = rx_sr[15:11];
    assign wr_data = rx_sr[7:0];
    assign wr_commit = frame_end && fall_cnt == pdcsw_pkg::FRAME_BITS && !rx_sr[pdcsw_pkg::FRAME_RW]
                       && !(^rx_sr[15:9]);

    logic ctrl_write, hsout_write, high_side_status_write, wd_write, kick;
    assign ctrl_write = wr_commit && wr_addr == pdcsw_pkg::ADDR_SYS_CTRL;
    assign hsout_write = wr_commit && wr_addr == pdcsw_pkg::ADDR_HS_OUT;
    assign high_side_status_write = wr_commit && wr_addr == pdcsw_pkg::ADDR_HS_STAT;
    assign wd_write = wr_commit && wr_addr == pdcsw_pkg::ADDR_WDOG_CTRL;
    assign kick = wd_write && wr_data[pdcsw_pkg::WDOG_KICK];

    // system_control
    logic pse, tsd_lower_dis, tsd_upper_dis, vsd_dis;
    logic [1:0] lin_slew;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pse <= 1'b0;
            tsd_lower_dis <= 1'b0;
            tsd_upper_dis <= 1'b0;
            vsd_dis <= 1'b0;
            lin_slew <= 2'h0;
        end else if (ctrl_write) begin
            pse <= wr_data[pdcsw_pkg::CTRL_PSE];
            tsd_lower_dis <= wr_data[pdcsw_pkg::CTRL_TSD_LOWER];
            tsd_upper_dis <= wr_data[pdcsw_pkg::CTRL_TSD_UPPER];
            vsd_dis <= wr_data[pdcsw_pkg::CTRL_VSD];
            lin_slew <= wr_data[1:0];
        end
    end
    assign lin_slew_select_o = lin_slew;

    // a request in the same cycle as the interrupt wins
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            stop_req <= 1'b0;
            sleep_req <= 1'b0;
        end else begin
            if (ctrl_write && wr_data[pdcsw_pkg::CTRL_STOP] && (wr_data & pdcsw_pkg::STOP_QUAL_MASK) == 8'h00) begin
                stop_req <= 1'b1;
            end else if (cpu_irq) begin
                stop_req <= 1'b0;
            end
            if (ctrl_write && wr_data[pdcsw_pkg::CTRL_SLEEP] && (wr_data & pdcsw_pkg::SLEEP_QUAL_MASK) == 8'h00) begin
                sleep_req <= 1'b1;
            end else if (cpu_irq) begin
                sleep_req <= 1'b0;
            end
        end
    end
    assign stop_req_o = stop_req;
    assign sleep_req_o = sleep_req;

    // high side output register
    logic sv_on;
    logic [2:0] follow_pwm, hs_on;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sv_on <= 1'b0;
            follow_pwm <= 3'h0;
            hs_on <= 3'h0;
        end else if (hsout_write) begin
            sv_on <= wr_data[pdcsw_pkg::HSOUT_5V_ON];
            follow_pwm <= wr_data[5:3];
            hs_on <= wr_data[2:0];
        end
    end

    // overcurrent flags and trip latches; a new event beats the clearing write
    logic [2:0] hs_flag, hs_trip, hs_clr;
    logic sv_flag, sv_trip, sv_clr;
    assign hs_clr = high_side_status_write ? wr_data[2:0] : 3'h0;
    assign sv_clr = high_side_status_write && wr_data[pdcsw_pkg::HIGH_SIDE_STATUS_5V_OCF];
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            hs_flag <= 3'h0;
            hs_trip <= 3'h0;
        end else begin
            hs_flag <= (hs_flag & ~hs_clr) | hs_oc;
            // with both on and pwm set the driver rides the limit instead of tripping
            hs_trip <= (hs_trip & ~(hs_clr | (follow_pwm & {3{pwm_rise}})))
                       | (hs_oc & ~(follow_pwm & hs_on));
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sv_flag <= 1'b0;
            sv_trip <= 1'b0;
        end else begin
            sv_flag <= (sv_flag & ~sv_clr) | sv_oc;
            sv_trip <= (sv_trip & ~sv_clr) | sv_oc;
        end
    end

    // lin transmitter is cut after staying too long in current limit
    logic [15:0] lin_cl_cnt;
    logic lin_cl_off;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || !pse) begin
            lin_cl_cnt <= 16'h0000;
            lin_cl_off <= 1'b0;
        end else if (!lin_cl) begin
            lin_cl_cnt <= 16'h0000;
        end else if (lin_cl_cnt == 16'(LIN_CL_CYCLES - 1)) begin
            lin_cl_off <= 1'b1;
        end else begin
            lin_cl_cnt <= lin_cl_cnt + 16'h0001;
        end
    end

    // protective shutdowns and power gating
    logic volt_fail, upper_off, lower_off, volt_off;
    assign volt_fail = lv_flag | hv_flag;
    assign upper_off = ot_flag & ~tsd_upper_dis;
    assign lower_off = ot_flag & ~tsd_lower_dis;
    assign volt_off = volt_fail & ~vsd_dis;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            hs_drive_o <= 3'h0;
            hb_upper_en_o <= 4'h0;
            hb_lower_en_o <= 4'h0;
            switched_5v_output_o <= 1'b0;
            lin_tx_en_o <= 1'b0;
            ain_source_en_o <= 1'b0;
        end else begin
            hs_drive_o <= {3{pse & ~upper_off & ~volt_off}} & ~hs_trip
                          & (hs_on | (follow_pwm & {3{pwm}}));
            hb_upper_en_o <= {4{pse & ~upper_off & ~volt_off}};
            hb_lower_en_o <= {4{pse & ~lower_off & ~volt_off}};
            // supply faults do not touch the switched 5v output
            switched_5v_output_o <= pse & sv_on & ~sv_trip;
            lin_tx_en_o <= pse & ~lin_cl_off;
            ain_source_en_o <= pse;
        end
    end

    // read-only status summary
    assign sys_status = {lin_cl, ot_flag, volt_fail, aux_oc, sv_flag, |hs_flag, |hb_oc, 1'b0};

    // window watchdog
    logic wdog_en;
    logic [1:0] wdog_sel;
    logic [22:0] wdog_cnt, wdog_period;
    logic stop_wake, expire, early_kick;
    assign wdog_period = wdog_period_cycles(wdog_sel);
    assign stop_wake = stop_d & ~stop_req;
    assign expire = wdog_en && !stop_req && !sleep_req && wdog_cnt == wdog_period - 23'h000001;
    assign early_kick = wdog_en && kick && wdog_cnt < (wdog_period >> 1);
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            wdog_en <= 1'b0;
            wdog_sel <= 2'h0;
        end else begin
            if (sleep_req) begin
                wdog_en <= 1'b0;
            end else if (wd_write && wr_data[pdcsw_pkg::WDOG_ENABLE]) begin
                wdog_en <= 1'b1;
            end
            if (wd_write) begin
                wdog_sel <= wr_data[1:0];
            end
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            wdog_cnt <= 23'h000000;
            wdog_reset_o <= 1'b0;
        end else begin
            wdog_reset_o <= expire | early_kick;
            if (!wdog_en || sleep_req || stop_wake || kick || expire) begin
                wdog_cnt <= 23'h000000;
            end else if (!stop_req) begin
                wdog_cnt <= wdog_cnt + 23'h000001;
            end
        end
    end

    // register read mux
    always_comb begin
        case (rx_sr[5:1])
            pdcsw_pkg::ADDR_SYS_CTRL: rd_data = {pse, 2'b00, tsd_lower_dis, tsd_upper_dis, vsd_dis, lin_slew};
            pdcsw_pkg::ADDR_HS_OUT: rd_data = {sv_on, 1'b0, follow_pwm, hs_on};
            pdcsw_pkg::ADDR_HS_STAT: rd_data = {sv_flag, 4'h0, hs_flag};
            pdcsw_pkg::ADDR_WDOG_CTRL: rd_data = {wdog_en, 5'h00, wdog_sel};
            pdcsw_pkg::ADDR_SYS_STAT: rd_data = sys_status;
            default: rd_data = 8'h00;
        endcase
    end

    chk_stop_qualify: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (ctrl_write && !stop_req && (wr_data & pdcsw_pkg::STOP_QUAL_MASK) != 8'h00) |=> !stop_req)
        else $error("stop accepted with other control bits set");
    chk_sleep_qualify: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (ctrl_write && !sleep_req && (wr_data & pdcsw_pkg::SLEEP_QUAL_MASK) != 8'h00) |=> !sleep_req)
        else $error("sleep accepted with other control bits set");
    chk_hs_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (hs_oc != 3'h0) |=> ((hs_flag & $past(hs_oc)) == $past(hs_oc)))
        else $error("high side overcurrent did not set its flag");
    chk_5v_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (sv_clr && !sv_oc) |=> (!sv_flag && !sv_trip) ##1 (switched_5v_output_o == $past(pse && sv_on)))
        else $error("5v flag not cleared by write one");
    chk_power_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !pse |=> (hs_drive_o == 3'h0 && hb_upper_en_o == 4'h0 && !switched_5v_output_o && !lin_tx_en_o))
        else $error("power output active while power stages disabled");
    chk_wdog_once: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (wdog_en && !sleep_req) |=> wdog_en)
        else $error("watchdog enable cleared by software");
    chk_early_kick: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        early_kick |=> (wdog_reset_o && wdog_cnt == 23'h000000))
        else $error("kick in closed window did not reset");
    chk_stop_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (stop_req && wdog_en && !kick && !sleep_req) |=> $stable(wdog_cnt))
        else $error("watchdog counted during stop");
    chk_sleep_disable: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        sleep_req |=> (!wdog_en && wdog_cnt == 23'h000000))
        else $error("watchdog still enabled in sleep");
    chk_write_at_end: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !frame_end |=> ($stable(pse) && $stable(wdog_sel) && $stable(follow_pwm)))
        else $error("register changed outside slave select rise");

endmodule

// *** pdcsw_spi_host.sv ***
// serial link host model that frames address and data toward the power die
`timescale 1ns/1ps
module pdcsw_spi_host (
    input wire logic clk_sys_i,
    input wire logic miso_i,
    output logic ss_b_o,
    output logic sck_o,
    output logic mosi_o
);
    // link clock stands still between frames, data line idles at its pull-down level
    initial begin
        ss_b_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end

    // half period of four system clocks gives the 160 ns link clock
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        ss_b_o = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        for (int i = 0; i < nbits; i++) begin
            sck_o = 1'b1;
            mosi_o = tx[15 - i];
            repeat (4) @(negedge clk_sys_i);
            sck_o = 1'b0;
            rx = {rx[14:0], miso_i};
            repeat (4) @(negedge clk_sys_i);
        end
        ss_b_o = 1'b1;
        mosi_o = 1'b0;
        repeat (6) @(negedge clk_sys_i);
    endtask
endmodule

// *** pdcsw_core_tb_top.sv ***
// self-checking bench for the power die control, status and watchdog block
`timescale 1ns/1ps
module pdcsw_core_tb_top;
    localparam int WB = 256;
    typedef struct packed {
        logic [4:0] a;
        logic [7:0] d;
        logic [7:0] q;
        logic [5:0] si;
        logic [7:0] so;
        logic [1:0] sl;
    } pdcsw_row_t;
    // status inputs: lin limit, overtemp, low volt, high volt, aux flag, bridge 3 overcurrent
    pdcsw_row_t rows [9] = '{
        '{5'h00, 8'h01, 8'h01, 6'h20, 8'h80, 2'h1},
        '{5'h00, 8'h1E, 8'h1E, 6'h10, 8'h40, 2'h2},
        '{5'h00, 8'h03, 8'h03, 6'h08, 8'h20, 2'h3},
        '{5'h00, 8'hFE, 8'h9E, 6'h04, 8'h20, 2'h2},
        '{5'h02, 8'hFF, 8'hBF, 6'h02, 8'h10, 2'h2},
        '{5'h0B, 8'h03, 8'h03, 6'h01, 8'h02, 2'h2},
        '{5'h1F, 8'hFF, 8'h00, 6'h00, 8'h00, 2'h2},
        '{5'h02, 8'h00, 8'h00, 6'h00, 8'h00, 2'h2},
        '{5'h00, 8'h00, 8'h00, 6'h00, 8'h00, 2'h0}
    };
    logic [4:0] reg_addr [4] = '{5'h00, 5'h02, 5'h04, 5'h0B};
    logic [7:0] mode_wr [4] = '{8'h40, 8'h44, 8'h20, 8'h30};
    logic [1:0] mode_exp [4] = '{2'h2, 2'h0, 2'h1, 2'h0};
    logic clk_sys_i, rst_b_i, ss_b, sck, mosi, miso, pwm_i, switched_5v_oc_i, aux_i, lin_cl_i;
    logic ot_i, lv_i, hv_i, cpu_irq_i, switched_5v_output_o, lin_tx_en_o, ain_source_en_o;
    logic stop_req_o, sleep_req_o, wdog_reset_o, miso_oe;
    logic [2:0] hs_oc_i, hs_drive_o;
    logic [3:0] hb_oc_i, hb_upper_en_o, hb_lower_en_o;
    logic [1:0] lin_slew_select_o;
    logic [15:0] r;
    int miscompares = 0, total_checks = 0, cyc = 0, n, pulses = 0;

    pdcsw_spi_host host (.clk_sys_i(clk_sys_i), .miso_i(miso), .ss_b_o(ss_b), .sck_o(sck), .mosi_o(mosi));
    pdcsw_core #(.WDOG_BASE_CYCLES(WB), .LIN_CL_CYCLES(16)) dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .spi_ss_b_i(ss_b), .spi_sck_i(sck), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .pwm_i(pwm_i), .hs_oc_i(hs_oc_i),
        .switched_5v_oc_i(switched_5v_oc_i), .aux_high_side_overcurrent_flag_i(aux_i), .hb_oc_i(hb_oc_i),
        .lin_cl_i(lin_cl_i), .overtemperature_flag_i(ot_i), .low_voltage_flag_i(lv_i),
        .high_voltage_flag_i(hv_i), .cpu_irq_i(cpu_irq_i), .hs_drive_o(hs_drive_o),
        .hb_upper_en_o(hb_upper_en_o), .hb_lower_en_o(hb_lower_en_o),
        .switched_5v_output_o(switched_5v_output_o), .lin_tx_en_o(lin_tx_en_o),
        .ain_source_en_o(ain_source_en_o), .lin_slew_select_o(lin_slew_select_o),
        .stop_req_o(stop_req_o), .sleep_req_o(sleep_req_o), .wdog_reset_o(wdog_reset_o));

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task automatic give_verdict;
        if (miscompares == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // even parity over address and direction
    function automatic logic [15:0] frm(input logic [4:0] a, input logic rw, input logic [7:0] d);
        frm = {a, rw, ^{a, rw}, 1'b0, d};
    endfunction

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [15:0] rx;
        host.xfer(frm(a, 1'b0, d), 16, rx);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        host.xfer(frm(a, 1'b1, 8'h00), 16, r);
        chk(r[7:0], exp);
    endtask

    // inputs pass a two-flop synchroniser, so give the outputs time to land
    task automatic st;
        repeat (8) @(negedge clk_sys_i);
    endtask

    task automatic irq;
        cpu_irq_i = 1'b1;
        st();
        cpu_irq_i = 1'b0;
        st();
    endtask

    // counts until a watchdog pulse is seen, then steps past it
    task automatic wpulse(input int lim, output int cnt);
        cnt = 0;
        while (wdog_reset_o !== 1'b1 && cnt < lim) begin
            @(negedge clk_sys_i);
            cnt++;
        end
        if (wdog_reset_o === 1'b1) @(negedge clk_sys_i);
    endtask

    task automatic do_reset;
        rst_b_i = 1'b0;
        repeat (16) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
    endtask

    // a reset pulse can fall inside a frame task, so every pulse is counted here
    always @(negedge clk_sys_i) begin
        cyc++;
        if (wdog_reset_o === 1'b1) pulses++;
        if (cyc > 60000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        {rst_b_i, pwm_i, switched_5v_oc_i, aux_i, lin_cl_i, ot_i, lv_i, hv_i, cpu_irq_i} = 9'h000;
        hs_oc_i = 3'h0;
        hb_oc_i = 4'h0;
        @(negedge clk_sys_i);
        do_reset();
        for (int i = 0; i < 9; i++) begin
            {lin_cl_i, ot_i, lv_i, hv_i, aux_i} = rows[i].si[5:1];
            hb_oc_i = {rows[i].si[0], 3'h0};
            st();
            wr(rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].q);
            chk(r[15:8], rows[i].so);
            chk(lin_slew_select_o, rows[i].sl);
            chk({stop_req_o, sleep_req_o}, 2'h0);
        end
        wr(5'h00, 8'h83);
        do_reset();
        chk({hs_drive_o, hb_upper_en_o, hb_lower_en_o, switched_5v_output_o, lin_tx_en_o, ain_source_en_o,
            lin_slew_select_o, stop_req_o, sleep_req_o, wdog_reset_o, miso_oe}, 32'h0);
        for (int i = 0; i < 4; i++) rdchk(reg_addr[i], 8'h00);
        // bad parity and a short frame must both be dropped
        host.xfer(frm(5'h00, 1'b0, 8'h03) ^ 16'h0200, 16, r);
        host.xfer(frm(5'h00, 1'b0, 8'h03), 15, r);
        rdchk(5'h00, 8'h00);
        wr(5'h00, 8'h80);
        st();
        chk({ain_source_en_o, lin_tx_en_o, hb_upper_en_o, hb_lower_en_o}, 10'h3FF);
        ot_i = 1'b1;
        st();
        chk({hb_upper_en_o, hb_lower_en_o}, 8'h00);
        wr(5'h00, 8'h98);
        st();
        chk({hb_upper_en_o, hb_lower_en_o}, 8'hFF);
        ot_i = 1'b0;
        lv_i = 1'b1;
        wr(5'h00, 8'h80);
        st();
        chk(hb_upper_en_o, 4'h0);
        wr(5'h00, 8'h84);
        st();
        chk(hb_upper_en_o, 4'hF);
        lv_i = 1'b0;
        lin_cl_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        chk(lin_tx_en_o, 1'b1);
        repeat (30) @(negedge clk_sys_i);
        chk(lin_tx_en_o, 1'b0);
        lin_cl_i = 1'b0;
        wr(5'h02, 8'h08);
        pwm_i = 1'b1;
        st();
        chk(hs_drive_o, 3'h1);
        pwm_i = 1'b0;
        st();
        chk(hs_drive_o, 3'h0);
        pwm_i = 1'b1;
        hs_oc_i = 3'h1;
        st();
        chk(hs_drive_o, 3'h0);
        rdchk(5'h04, 8'h01);
        chk(r[15:8], 8'h04);
        hs_oc_i = 3'h0;
        pwm_i = 1'b0;
        st();
        pwm_i = 1'b1;
        st();
        chk(hs_drive_o, 3'h1);
        wr(5'h04, 8'h00);
        rdchk(5'h04, 8'h01);
        wr(5'h04, 8'h01);
        rdchk(5'h04, 8'h00);
        // both bits set: overcurrent flags the driver but must not cut it
        wr(5'h02, 8'h09);
        hs_oc_i = 3'h1;
        st();
        chk(hs_drive_o, 3'h1);
        hs_oc_i = 3'h0;
        rdchk(5'h04, 8'h01);
        wr(5'h04, 8'h01);
        wr(5'h02, 8'h80);
        st();
        chk(switched_5v_output_o, 1'b1);
        switched_5v_oc_i = 1'b1;
        st();
        switched_5v_oc_i = 1'b0;
        st();
        chk(switched_5v_output_o, 1'b0);
        rdchk(5'h04, 8'h80);
        chk(r[15:8], 8'h08);
        wr(5'h04, 8'h80);
        st();
        chk(switched_5v_output_o, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(5'h00, mode_wr[i]);
            st();
            chk({stop_req_o, sleep_req_o}, mode_exp[i]);
            irq();
            chk({stop_req_o, sleep_req_o}, 2'h0);
        end
        wr(5'h0B, 8'h83);
        rdchk(5'h0B, 8'h83);
        wr(5'h0B, 8'h03);
        rdchk(5'h0B, 8'h83);
        // periods only grow here, so the running count never overshoots a shorter end value
        for (int s = 3; s >= 0; s--) begin
            wr(5'h0B, 8'h80 | 8'(s));
            wpulse(5000, n);
            wpulse(5000, n);
            chk(n + 1, WB << (3 - s));
        end
        n = pulses;
        wr(5'h0B, 8'hC0);
        chk(pulses - n, 1);
        n = pulses;
        repeat (1100) @(negedge clk_sys_i);
        wr(5'h0B, 8'hC0);
        chk(pulses - n, 0);
        wpulse(5000, n);
        chk(32'(n > 1700 && n < 2100), 1);
        wr(5'h0B, 8'h83);
        wpulse(600, n);
        wr(5'h00, 8'h40);
        wpulse(600, n);
        chk(n, 600);
        cpu_irq_i = 1'b1;
        @(negedge clk_sys_i);
        cpu_irq_i = 1'b0;
        wpulse(600, n);
        chk(32'(n > 240 && n < 270), 1);
        wr(5'h00, 8'h20);
        rdchk(5'h0B, 8'h03);
        irq();
        wpulse(600, n);
        chk(n, 600);
        give_verdict();
    end
endmodule
